// ### psc_pkg.sv
// Purpose: Shared constants for the pressure sensor measurement command block.
// Assumes: Core clock of 200 MHz; all times below are in nanoseconds.
// Notes: Cycle counts are derived from the printed times and the clock period.
package psc_pkg;

    localparam int CLK_PERIOD_NS = 5;
    localparam int T_FIRST_NS = 8_000_000;
    localparam int T_SETTLE_NS = 12_000_000;
    localparam int T_SAMPLE_NS = 500_000;
    localparam int T_RECOV_NS = 500_000;
    localparam int T_CONV_NS = 45_000_000;
    localparam int T_AVG_LIN_NS = 25_000_000;

    localparam int FIRST_CYC = (T_FIRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SAMPLE_CYC = T_SAMPLE_NS / CLK_PERIOD_NS;
    localparam int RECOV_CYC = (T_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_CYC = (T_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AVG_LIN_SAMPLES = T_AVG_LIN_NS / T_SAMPLE_NS;
    localparam int EMA_DIVISOR = 20;

    localparam logic [6:0] ADDR_MAIN = 7'h25;
    localparam logic [6:0] ADDR_ALT = 7'h26;

    localparam logic [15:0] CMD_CONT_MF_AVG = 16'h3603;
    localparam logic [15:0] CMD_CONT_MF = 16'h3608;
    localparam logic [15:0] CMD_CONT_DP_AVG = 16'h3615;
    localparam logic [15:0] CMD_CONT_DP = 16'h361e;
    localparam logic [15:0] CMD_STOP = 16'h3ff9;
    localparam logic [15:0] CMD_TRIG_MF = 16'h3624;
    localparam logic [15:0] CMD_TRIG_DP = 16'h362f;
    localparam logic [15:0] CMD_TRIG_MF_STR = 16'h3726;
    localparam logic [15:0] CMD_TRIG_DP_STR = 16'h372d;

    localparam logic [7:0] CRC_POLY = 8'h31;
    localparam logic [7:0] CRC_INIT = 8'hff;
    localparam logic [15:0] SCALE_PA_DEFAULT = 16'h003c;
    localparam int RESULT_BYTES = 9;

    typedef enum logic [1:0] {
        MD_IDLE = 2'b00,
        MD_CONT = 2'b01,
        MD_TRIG = 2'b10,
        MD_RECOV = 2'b11
    } psc_mode_type;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0000,
        S_ADDR = 4'b0001,
        S_AACK = 4'b0010,
        S_AHOLD = 4'b0011,
        S_RX = 4'b0100,
        S_RACK = 4'b0101,
        S_RHOLD = 4'b0110,
        S_TX = 4'b0111,
        S_MACK = 4'b1000,
        S_STRETCH = 4'b1001
    } psc_i2c_state_type;

endpackage

// ### psc_meas_cmd.sv
// Purpose: I2C target command interpreter for start/stop/triggered measurements.
// Assumes: SCL and SDA are sampled by i_clk; samples arrive from the front end.
// Notes: Two-way pins are split into input, output and active-low enable.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module psc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign o_in_ready = (count_reg != (AW + 1)'(DEPTH));
    assign o_out_valid = (count_reg != '0);
    assign o_out_data = mem[rd_ptr_reg];
    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module psc_meas_cmd #(
    parameter int FIRST_CYC = psc_pkg::FIRST_CYC,
    parameter int SAMPLE_CYC = psc_pkg::SAMPLE_CYC,
    parameter int RECOV_CYC = psc_pkg::RECOV_CYC,
    parameter int CONV_CYC = psc_pkg::CONV_CYC,
    parameter int FIFO_DEPTH = 4,
    parameter logic [15:0] SCALE_PA = psc_pkg::SCALE_PA_DEFAULT
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_addr_alt,
    input wire logic i_scl,
    output logic o_scl,
    output logic o_scl_oe_b,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe_b,
    input wire logic i_smp_valid,
    output logic o_smp_ready,
    input wire logic [15:0] i_smp_pressure,
    input wire logic [15:0] i_smp_temp,
    output logic o_heater_on,
    output logic o_comp_mass_flow
);
    import psc_pkg::*;

    function automatic logic [7:0] crc8(input logic [15:0] word);
        logic [7:0] crc;
        crc = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            crc = (crc[7] ^ word[i]) ? ({crc[6:0], 1'b0} ^ CRC_POLY) : {crc[6:0], 1'b0};
        end
        return crc;
    endfunction

    function automatic logic [7:0] tx_byte(input logic [3:0] idx, input logic [15:0] p,
                                           input logic [15:0] t, input logic [15:0] s);
        logic [7:0] b;
        unique case (idx)
            4'h0: b = p[15:8];
            4'h1: b = p[7:0];
            4'h2: b = crc8(p);
            4'h3: b = t[15:8];
            4'h4: b = t[7:0];
            4'h5: b = crc8(t);
            4'h6: b = s[15:8];
            4'h7: b = s[7:0];
            4'h8: b = crc8(s);
            default: b = 8'hff;
        endcase
        return b;
    endfunction

    function automatic logic [15:0] mean16(input logic signed [23:0] sum, input logic [6:0] n);
        logic signed [23:0] q;
        q = sum / $signed({17'h0, n});
        return q[15:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic scl_m_reg, scl_s_reg, scl_p_reg, sda_m_reg, sda_s_reg, sda_p_reg;
    logic addr_m_reg, addr_s_reg;
    logic scl_rise, scl_fall, start_det, stop_det;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            scl_m_reg <= 1'b1;
            scl_s_reg <= 1'b1;
            scl_p_reg <= 1'b1;
            sda_m_reg <= 1'b1;
            sda_s_reg <= 1'b1;
            sda_p_reg <= 1'b1;
            addr_m_reg <= 1'b0;
            addr_s_reg <= 1'b0;
        end else begin
            scl_m_reg <= i_scl;
            scl_s_reg <= scl_m_reg;
            scl_p_reg <= scl_s_reg;
            sda_m_reg <= i_sda;
            sda_s_reg <= sda_m_reg;
            sda_p_reg <= sda_s_reg;
            addr_m_reg <= i_addr_alt;
            addr_s_reg <= addr_m_reg;
        end
    end

    assign scl_rise = scl_s_reg & ~scl_p_reg;
    assign scl_fall = ~scl_s_reg & scl_p_reg;
    assign start_det = scl_s_reg & scl_p_reg & sda_p_reg & ~sda_s_reg;
    assign stop_det = scl_s_reg & scl_p_reg & ~sda_p_reg & sda_s_reg;

    ////////////////////////////////////////////////////////////////////////////
    psc_mode_type mode_reg;
    psc_i2c_state_type st_reg;
    logic [23:0] timer_reg;
    logic [16:0] spl_cnt_reg;
    logic avg_en_reg, stretch_en_reg, comp_mf_reg, first_done_reg, data_ok_reg, have_res_reg;
    logic [2:0] cnt_reg;
    logic [7:0] sh_reg, tx_sh_reg, cmd_hi_reg;
    logic [15:0] cmd_code_reg;
    logic [3:0] byte_idx_reg;
    logic rw_reg, ack_reg, had_data_reg, cmd_idx_reg, cmd_fire_reg, snap_take_reg;
    logic sda_low_reg, scl_low_reg;
    logic [15:0] res_p_reg, res_t_reg, snap_p_reg, snap_t_reg;
    logic signed [23:0] sum_p_reg, sum_t_reg;
    logic [6:0] n_reg;
    logic fifo_valid, pop, spl_tick, conv_end, hdr_match, wr_ok, rd_ok;
    logic [31:0] fifo_data;
    logic [15:0] x_p, x_t;
    logic [7:0] first_tx;

    assign hdr_match = (sh_reg[6:0] == (addr_s_reg ? ADDR_ALT : ADDR_MAIN));
    assign wr_ok = (mode_reg == MD_IDLE) || (mode_reg == MD_CONT);
    assign rd_ok = data_ok_reg || ((mode_reg == MD_TRIG) && stretch_en_reg);
    assign spl_tick = (spl_cnt_reg == 17'(SAMPLE_CYC - 1));
    assign conv_end = (mode_reg == MD_TRIG) && (timer_reg >= 24'(CONV_CYC - 1));
    assign pop = fifo_valid & (((mode_reg == MD_CONT) & spl_tick) | conv_end);
    assign x_p = fifo_data[31:16];
    assign x_t = fifo_data[15:0];
    assign first_tx = tx_byte(4'h0, snap_p_reg, snap_t_reg, SCALE_PA);

    psc_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_in_valid(i_smp_valid),
        .o_in_ready(o_smp_ready),
        .i_in_data({i_smp_pressure, i_smp_temp}),
        .o_out_valid(fifo_valid),
        .i_out_ready(pop),
        .o_out_data(fifo_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Commands only take effect once both bytes are acknowledged.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mode_reg <= MD_IDLE;
            timer_reg <= '0;
            spl_cnt_reg <= '0;
            avg_en_reg <= 1'b0;
            stretch_en_reg <= 1'b0;
            comp_mf_reg <= 1'b0;
            first_done_reg <= 1'b0;
            data_ok_reg <= 1'b0;
        end else begin
            spl_cnt_reg <= spl_tick ? '0 : spl_cnt_reg + 1'b1;
            if (timer_reg != 24'hffffff) begin
                timer_reg <= timer_reg + 1'b1;
            end
            if (cmd_fire_reg && mode_reg == MD_IDLE) begin
                unique case (cmd_code_reg)
                    CMD_CONT_MF_AVG, CMD_CONT_MF, CMD_CONT_DP_AVG, CMD_CONT_DP: begin
                        mode_reg <= MD_CONT;
                        comp_mf_reg <= (cmd_code_reg == CMD_CONT_MF_AVG) ||
                                       (cmd_code_reg == CMD_CONT_MF);
                        avg_en_reg <= (cmd_code_reg == CMD_CONT_MF_AVG) ||
                                      (cmd_code_reg == CMD_CONT_DP_AVG);
                        timer_reg <= '0;
                        first_done_reg <= 1'b0;
                        data_ok_reg <= 1'b0;
                    end
                    CMD_TRIG_MF, CMD_TRIG_DP, CMD_TRIG_MF_STR, CMD_TRIG_DP_STR: begin
                        mode_reg <= MD_TRIG;
                        comp_mf_reg <= (cmd_code_reg == CMD_TRIG_MF) ||
                                       (cmd_code_reg == CMD_TRIG_MF_STR);
                        stretch_en_reg <= (cmd_code_reg == CMD_TRIG_MF_STR) ||
                                          (cmd_code_reg == CMD_TRIG_DP_STR);
                        avg_en_reg <= 1'b0;
                        timer_reg <= '0;
                        data_ok_reg <= 1'b0;
                    end
                    CMD_STOP: begin
                        mode_reg <= MD_RECOV;
                        timer_reg <= '0;
                    end
                    default: begin
                    end
                endcase
            end else if (cmd_fire_reg && mode_reg == MD_CONT && cmd_code_reg == CMD_STOP) begin
                mode_reg <= MD_RECOV;
                timer_reg <= '0;
                data_ok_reg <= 1'b0;
            end else begin
                unique case (mode_reg)
                    MD_CONT: begin
                        if (timer_reg == 24'(FIRST_CYC - 1)) begin
                            first_done_reg <= 1'b1;
                        end
                        data_ok_reg <= first_done_reg & have_res_reg;
                    end
                    MD_TRIG: begin
                        if (pop) begin
                            mode_reg <= MD_IDLE;
                            data_ok_reg <= 1'b1;
                        end
                    end
                    MD_RECOV: begin
                        if (timer_reg >= 24'(RECOV_CYC - 1)) begin
                            mode_reg <= MD_IDLE;
                        end
                    end
                    MD_IDLE: begin
                    end
                endcase
            end
        end
    end

    // The heater only runs while a conversion is in progress.
    assign o_heater_on = (mode_reg == MD_CONT) || (mode_reg == MD_TRIG);
    assign o_comp_mass_flow = comp_mf_reg;

    ////////////////////////////////////////////////////////////////////////////
    // A read restarts the average; a sample in the same cycle seeds it.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            res_p_reg <= '0;
            res_t_reg <= '0;
            sum_p_reg <= '0;
            sum_t_reg <= '0;
            n_reg <= '0;
            have_res_reg <= 1'b0;
        end else begin
            if (cmd_fire_reg && mode_reg == MD_IDLE) begin
                n_reg <= '0;
                sum_p_reg <= '0;
                sum_t_reg <= '0;
                have_res_reg <= 1'b0;
            end else if (pop) begin
                have_res_reg <= 1'b1;
                if (!avg_en_reg) begin
                    res_p_reg <= x_p;
                    res_t_reg <= x_t;
                end else if (snap_take_reg || n_reg < 7'(AVG_LIN_SAMPLES)) begin
                    sum_p_reg <= (snap_take_reg ? 24'sd0 : sum_p_reg) + 24'($signed(x_p));
                    sum_t_reg <= (snap_take_reg ? 24'sd0 : sum_t_reg) + 24'($signed(x_t));
                    n_reg <= (snap_take_reg ? 7'd0 : n_reg) + 7'd1;
                    res_p_reg <= mean16((snap_take_reg ? 24'sd0 : sum_p_reg) +
                                        24'($signed(x_p)), (snap_take_reg ? 7'd0 : n_reg) + 7'd1);
                    res_t_reg <= mean16((snap_take_reg ? 24'sd0 : sum_t_reg) +
                                        24'($signed(x_t)), (snap_take_reg ? 7'd0 : n_reg) + 7'd1);
                end else begin
                    res_p_reg <= 16'($signed(res_p_reg) + ($signed(17'($signed(x_p))) -
                                 $signed(17'($signed(res_p_reg)))) / 17'sd20);
                    res_t_reg <= 16'($signed(res_t_reg) + ($signed(17'($signed(x_t))) -
                                 $signed(17'($signed(res_t_reg)))) / 17'sd20);
                end
            end else if (snap_take_reg && avg_en_reg) begin
                n_reg <= '0;
                sum_p_reg <= '0;
                sum_t_reg <= '0;
            end
            if (snap_take_reg) begin
                snap_p_reg <= res_p_reg;
                snap_t_reg <= res_t_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // SDA changes only after SCL falls so the controller never sees a false STOP.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_reg <= S_IDLE;
            cnt_reg <= '0;
            sh_reg <= '0;
            tx_sh_reg <= '0;
            cmd_hi_reg <= '0;
            cmd_code_reg <= '0;
            byte_idx_reg <= '0;
            rw_reg <= 1'b0;
            ack_reg <= 1'b0;
            had_data_reg <= 1'b0;
            cmd_idx_reg <= 1'b0;
            cmd_fire_reg <= 1'b0;
            snap_take_reg <= 1'b0;
            sda_low_reg <= 1'b0;
            scl_low_reg <= 1'b0;
        end else begin
            cmd_fire_reg <= 1'b0;
            snap_take_reg <= 1'b0;
            if (stop_det) begin
                st_reg <= S_IDLE;
                sda_low_reg <= 1'b0;
                scl_low_reg <= 1'b0;
            end else if (start_det) begin
                st_reg <= S_ADDR;
                cnt_reg <= '0;
                sda_low_reg <= 1'b0;
                scl_low_reg <= 1'b0;
            end else begin
                unique case (st_reg)
                    S_IDLE: begin
                    end
                    S_ADDR: if (scl_rise) begin
                        sh_reg <= {sh_reg[6:0], sda_s_reg};
                        cnt_reg <= cnt_reg + 1'b1;
                        if (cnt_reg == 3'd7) begin
                            st_reg <= S_AACK;
                            rw_reg <= sda_s_reg;
                            ack_reg <= hdr_match & (sda_s_reg ? rd_ok : wr_ok);
                            had_data_reg <= data_ok_reg;
                            snap_take_reg <= hdr_match & sda_s_reg & data_ok_reg;
                        end
                    end
                    S_AACK: if (scl_fall) begin
                        sda_low_reg <= ack_reg;
                        st_reg <= ack_reg ? S_AHOLD : S_IDLE;
                    end
                    S_AHOLD: if (scl_fall) begin
                        byte_idx_reg <= '0;
                        cmd_idx_reg <= 1'b0;
                        cnt_reg <= '0;
                        if (!rw_reg) begin
                            sda_low_reg <= 1'b0;
                            st_reg <= S_RX;
                        end else if (had_data_reg) begin
                            tx_sh_reg <= first_tx;
                            sda_low_reg <= ~first_tx[7];
                            st_reg <= S_TX;
                        end else begin
                            sda_low_reg <= 1'b0;
                            scl_low_reg <= 1'b1;
                            st_reg <= S_STRETCH;
                        end
                    end
                    S_STRETCH: begin
                        if (snap_take_reg) begin
                            tx_sh_reg <= first_tx;
                            sda_low_reg <= ~first_tx[7];
                            scl_low_reg <= 1'b0;
                            st_reg <= S_TX;
                        end else if (data_ok_reg) begin
                            snap_take_reg <= 1'b1;
                        end
                    end
                    S_TX: if (scl_fall) begin
                        cnt_reg <= cnt_reg + 1'b1;
                        if (cnt_reg == 3'd7) begin
                            sda_low_reg <= 1'b0;
                            st_reg <= S_MACK;
                        end else begin
                            sda_low_reg <= ~tx_sh_reg[6];
                            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
                        end
                    end
                    S_MACK: begin
                        if (scl_rise) begin
                            if (sda_s_reg) begin
                                st_reg <= S_IDLE;
                            end else begin
                                byte_idx_reg <= byte_idx_reg + 1'b1;
                            end
                        end else if (scl_fall) begin
                            tx_sh_reg <= tx_byte(byte_idx_reg, snap_p_reg, snap_t_reg,
                                                 SCALE_PA);
                            sda_low_reg <= ~tx_byte(byte_idx_reg, snap_p_reg, snap_t_reg,
                                                    SCALE_PA)[7];
                            st_reg <= S_TX;
                        end
                    end
                    S_RX: if (scl_rise) begin
                        sh_reg <= {sh_reg[6:0], sda_s_reg};
                        cnt_reg <= cnt_reg + 1'b1;
                        if (cnt_reg == 3'd7) begin
                            st_reg <= S_RACK;
                        end
                    end
                    S_RACK: if (scl_fall) begin
                        sda_low_reg <= 1'b1;
                        st_reg <= S_RHOLD;
                        cmd_idx_reg <= ~cmd_idx_reg;
                        if (!cmd_idx_reg) begin
                            cmd_hi_reg <= sh_reg;
                        end else begin
                            cmd_code_reg <= {cmd_hi_reg, sh_reg};
                            cmd_fire_reg <= 1'b1;
                        end
                    end
                    S_RHOLD: if (scl_fall) begin
                        sda_low_reg <= 1'b0;
                        st_reg <= S_RX;
                    end
                    default: st_reg <= S_IDLE;
                endcase
            end
        end
    end

    assign o_sda = 1'b0;
    assign o_sda_oe_b = ~sda_low_reg;
    assign o_scl = 1'b0;
    assign o_scl_oe_b = ~scl_low_reg;
endmodule

// ### psc_chk.sv
// Purpose: Port checks for psc_meas_cmd.
// Assumes: One clock domain; i_scl is the resolved wire level.
// Notes: Bound after the module.
`timescale 1ns/1ps
module psc_chk (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_scl,
    input wire logic o_scl,
    input wire logic o_scl_oe_b,
    input wire logic o_sda,
    input wire logic o_sda_oe_b,
    input wire logic o_heater_on,
    input wire logic o_comp_mass_flow
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    property p_rst; $rose(i_rst_b) |-> o_sda_oe_b && o_scl_oe_b && !o_heater_on; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_scl; o_scl == 1'b0; endproperty
    a_scl: assert property (p_scl) else $error("scl level");
    property p_sda; o_sda == 1'b0; endproperty
    a_sda: assert property (p_sda) else $error("sda level");
    property p_pull; $fell(o_sda_oe_b) |-> !i_scl; endproperty
    a_pull: assert property (p_pull) else $error("sda pulled with scl high");
    property p_str; $fell(o_scl_oe_b) |-> o_heater_on ##1 !o_scl_oe_b [*2]; endproperty
    a_str: assert property (p_str) else $error("stretch start");
    property p_rel; $rose(o_scl_oe_b) |-> !o_heater_on; endproperty
    a_rel: assert property (p_rel) else $error("stretch end");
    property p_off; $fell(o_heater_on) |=> !o_heater_on [*8]; endproperty
    a_off: assert property (p_off) else $error("heater off");
    property p_mf; $changed(o_comp_mass_flow) |=> o_heater_on; endproperty
    a_mf: assert property (p_mf) else $error("compensation change");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind psc_meas_cmd psc_chk psc_chk_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_scl(i_scl),
    .o_scl(o_scl), .o_scl_oe_b(o_scl_oe_b), .o_sda(o_sda), .o_sda_oe_b(o_sda_oe_b),
    .o_heater_on(o_heater_on), .o_comp_mass_flow(o_comp_mass_flow));

// ### psc_i2c_ctl.sv
// Purpose: Behavioural I2C controller on the far side.
// Assumes: The bench resolves the wired-AND levels.
// Notes: SCL stands high between frames; 48 ns bit period.
`timescale 1ns/1ps
module psc_i2c_ctl (
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    // The target may hold SCL low, so the high phase counts from when it is seen high.
    task automatic bit_x(input logic b, output logic r);
        int n;
        n = 0;
        #12 o_sda = b;
        #12 o_scl = 1'b1;
        while (i_scl !== 1'b1 && n < 100000) #5 n++;
        #24 r = i_sda;
        o_scl = 1'b0;
    endtask
    task automatic byte_x(input logic [7:0] d, input logic nk, output logic [7:0] q, output logic r);
        for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
        bit_x(nk, r);
    endtask
    task automatic start();
        #24 o_sda = 1'b0;
        #24 o_scl = 1'b0;
    endtask
    task automatic stop();
        #12 o_sda = 1'b0;
        #12 o_scl = 1'b1;
        #24 o_sda = 1'b1;
    endtask
endmodule

// ### tb_psc_meas_cmd.sv
// Purpose: Self-checking bench for psc_meas_cmd.
// Assumes: Shortened counts; samples held constant.
// Notes: Constant samples keep averaged results exact.
`timescale 1ns/1ps
module tb_psc_meas_cmd;
    import psc_pkg::*;
    typedef struct {logic [15:0] cmd; logic mf; int kind;} psc_row_type;
    psc_row_type rows [8] = '{'{CMD_CONT_MF_AVG, 1, 0}, '{CMD_CONT_MF, 1, 0},
        '{CMD_CONT_DP_AVG, 0, 0}, '{CMD_CONT_DP, 0, 0}, '{CMD_TRIG_MF, 1, 1},
        '{CMD_TRIG_DP, 0, 1}, '{CMD_TRIG_MF_STR, 1, 2}, '{CMD_TRIG_DP_STR, 0, 2}};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic alt = 1'b0;
    logic smp_v = 1'b1;
    logic [15:0] smp_p = 16'hbeef;
    logic [15:0] smp_t = 16'h1234;
    logic m_scl, m_sda, scl_oe_b, sda_oe_b, smp_ready, heater, comp, a;
    wire logic scl = m_scl & scl_oe_b;
    wire logic sda = m_sda & sda_oe_b;
    int err_total = 0;
    int total_checks = 0;
    logic [7:0] exp_b [9];
    logic [7:0] q;
    psc_meas_cmd #(.FIRST_CYC(200), .SAMPLE_CYC(20), .RECOV_CYC(400), .CONV_CYC(400))
        psc_meas_cmd_inst (.i_clk(clk), .i_rst_b(rst_b), .i_addr_alt(alt), .i_scl(scl), .o_scl(),
        .o_scl_oe_b(scl_oe_b), .i_sda(sda), .o_sda(), .o_sda_oe_b(sda_oe_b), .i_smp_valid(smp_v),
        .o_smp_ready(smp_ready), .i_smp_pressure(smp_p), .i_smp_temp(smp_t),
        .o_heater_on(heater), .o_comp_mass_flow(comp));
    psc_i2c_ctl psc_i2c_ctl_inst (.i_scl(scl), .i_sda(sda), .o_scl(m_scl), .o_sda(m_sda));
    always #2.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] crc(input logic [15:0] d);
        logic [7:0] c;
        c = 8'hff;
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h31 : 8'h00);
        return c;
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic hdr(input logic [7:0] h);
        psc_i2c_ctl_inst.start();
        psc_i2c_ctl_inst.byte_x(h, 1'b1, q, a);
    endtask
    task automatic cmd(input logic [15:0] c);
        hdr({ADDR_MAIN, 1'b0});
        psc_i2c_ctl_inst.byte_x(c[15:8], 1'b1, q, a);
        psc_i2c_ctl_inst.byte_x(c[7:0], 1'b1, q, a);
        psc_i2c_ctl_inst.stop();
    endtask
    // Polling spans the longest shortened wait with margin.
    task automatic rd(input int n);
        for (int t = 0; t < 50 && a !== 1'b0; t++) begin
            psc_i2c_ctl_inst.stop();
            #2000 hdr({ADDR_MAIN, 1'b1});
        end
        chk("read ack", 0, a);
        for (int k = 0; k < n; k++) begin
            psc_i2c_ctl_inst.byte_x(8'hff, k == n - 1, q, a);
            chk("result byte", {8'h00, exp_b[k]}, {8'h00, q});
        end
        psc_i2c_ctl_inst.stop();
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #400000 err_total++;
        complete_run();
    end
    initial begin
        exp_b = '{8'hbe, 8'hef, crc(16'hbeef), 8'h12, 8'h34, crc(16'h1234), 8'h00, 8'h3c,
            crc(SCALE_PA_DEFAULT)};
        repeat (8) @(posedge clk);
        chk("sda idle in reset", 1, sda_oe_b);
        #1 rst_b = 1'b1;
        repeat (40) @(posedge clk);
        chk("sample fifo full", 0, smp_ready);
        foreach (rows[i]) begin
            cmd(rows[i].cmd);
            hdr({ADDR_MAIN, 1'b1});
            if (rows[i].kind < 2) chk("early header", 1, a);
            rd(9);
            chk("compensation", rows[i].mf, comp);
            if (rows[i].kind == 0) begin
                cmd(CMD_TRIG_MF);
                chk("ignored command", rows[i].mf, comp);
                hdr({ADDR_MAIN, 1'b1});
                rd(2);
                cmd(CMD_STOP);
                chk("heater off", 0, heater);
                hdr({ADDR_MAIN, 1'b0});
                psc_i2c_ctl_inst.stop();
                chk("recovery header", 1, a);
                #2500;
            end
        end
        hdr({ADDR_ALT, 1'b0});
        psc_i2c_ctl_inst.stop();
        chk("other address", 1, a);
        alt = 1'b1;
        hdr({ADDR_ALT, 1'b0});
        psc_i2c_ctl_inst.stop();
        chk("strap address", 0, a);
        complete_run();
    end
endmodule
